// ==== rtl/rx_status_bank.sv ====
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rx_status_bank
  import rx_status_pkg::*;
(
  input  wire  logic        ref_clk,      // System clock, 20 MHz.
  input  wire  logic        nrst,         // Synchronous reset, active low.
  input  wire  logic        clk_en,       // Freezes all state when low.
  input  wire  logic        psel,         // APB select.
  input  wire  logic        penable,      // APB access phase.
  input  wire  logic        pwrite,       // APB direction.
  input  wire  logic [11:0] paddr,        // APB byte address.
  input  wire  logic [31:0] pwdata,       // APB write data.
  output var   logic [31:0] prdata,       // APB read data.
  output var   logic        pready,       // APB ready.
  output var   logic        pslverr,      // APB error, unmapped.
  input  wire  logic        byte_clk,     // Receiver byte clock pin.
  input  wire  logic        fifo_ovf_ev,  // Overflow level, byte domain.
  input  wire  logic        fifo_unf_ev,  // Underflow level, byte domain.
  input  wire  logic        buf_err_ev,   // Link buffer overflow.
  input  wire  logic        eot_miss_ev,  // Transmission end, no packet.
  input  wire  logic        hdr_valid,    // Packet header present.
  input  wire  logic [7:0]  hdr_id,       // Channel 7:6, type 5:0.
  input  wire  logic [7:0]  pkt_err,      // Packet error conditions.
  input  wire  logic [7:0]  lane_err,     // Lane error conditions.
  output var   logic        err_ind,      // Error status indication.
  output var   logic        irq           // Level interrupt.
);

  // ****************************************************************
  // Input synchronisers: three stages on every external event.
  // ****************************************************************
  localparam int NIN = 22; // Bits of external input in the bundle.
  logic [NIN-1:0] raw_in;  // Bundle of outside inputs.
  logic [NIN-1:0] s1;      // First stage, read only by s2.
  logic [NIN-1:0] s2;      // Second stage.
  logic [NIN-1:0] s3;      // Third stage.
  logic [NIN-1:0] stab;    // Value once s2 and s3 agree.
  logic [NIN-1:0] stab_d;  // Previous stable value for edges.

  assign raw_in = {byte_clk, fifo_ovf_ev, fifo_unf_ev, buf_err_ev,
                   eot_miss_ev, hdr_valid, hdr_id, pkt_err[7],
                   pkt_err[5:0], lane_err[6:6]};

  // Three flops per input; a change counts when stages two and three agree.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      stab   <= '0;
      stab_d <= '0;
    end
    else if (clk_en)
    begin
      s1     <= raw_in;
      s2     <= s1;
      s3     <= s2;
      stab_d <= stab;
      for (int i = 0; i < NIN; i++)
      begin
        if (s2[i] == s3[i])
        begin
          stab[i] <= s3[i];
        end
      end
    end
  end

  // Lane error bits 5:0 take a separate synchroniser bundle.
  logic [5:0] l1;    // First stage, read only by l2.
  logic [5:0] l2;    // Second stage.
  logic [5:0] l3;    // Third stage.
  logic [5:0] lstab; // Agreed value.

  // Same scheme for the remaining lane error bits.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      l1    <= '0;
      l2    <= '0;
      l3    <= '0;
      lstab <= '0;
    end
    else if (clk_en)
    begin
      l1 <= lane_err[5:0];
      l2 <= l1;
      l3 <= l2;
      for (int i = 0; i < 6; i++)
      begin
        if (l2[i] == l3[i])
        begin
          lstab[i] <= l3[i];
        end
      end
    end
  end

  // ****************************************************************
  // Event decode in the system domain.
  // ****************************************************************
  logic       bclk_rise; // Rising edge of byte clock seen.
  logic       ovf_evt;   // Overflow seen this cycle.
  logic       unf_evt;   // Underflow seen this cycle.
  logic       buf_evt;   // Link buffer error this cycle.
  logic       eot_evt;   // Missing end packet this cycle.
  logic       hdr_evt;   // Header taken this cycle.
  logic [7:0] hid;       // Synchronised header id.
  logic [7:0] pkt_now;   // Packet errors, report layout.
  logic [7:0] lane_now;  // Lane errors, report layout.
  logic [7:0] pkt_rise;  // New packet errors.
  logic [7:0] lane_rise; // New lane errors.
  logic       any_err;   // Some enabled error rose.
  logic [7:0] cfg;       // Mode controls and channel enables.
  logic [7:0] en0;       // Lane error enables.
  logic [7:0] en1;       // Packet error enables.
  logic [7:0] pkt_rpt;   // Packet error report.
  logic [7:0] lane_rpt;  // Lane error report.

  // Edges are taken on the agreed value; events are qualified by clock edge.
  assign bclk_rise = stab[21] & ~stab_d[21];
  assign ovf_evt   = bclk_rise & stab[20];
  assign unf_evt   = bclk_rise & stab[19];
  assign buf_evt   = bclk_rise & stab[18];
  assign eot_evt   = bclk_rise & stab[17] & ~cfg[CFG_NO_EOT];
  assign hdr_evt   = bclk_rise & stab[16];
  assign hid       = stab[15:8];
  // Packet report: protocol 7, length 5, channel 4, type 3, crc 2, ecc 1:0.
  assign pkt_now   = {stab[7], 1'b0, stab[6:1]};
  // Lane report: control 6, timeout 5 down to start 0.
  assign lane_now  = {1'b0, stab[0], lstab};
  assign pkt_rise  = pkt_now & ~pkt_rpt;
  assign lane_rise = lane_now & ~lane_rpt;

  // Enables map: en1 bit 3 gates the invalid channel bit, others alike.
  assign any_err = |(pkt_rise & {en1[5], 1'b0, en1[4], en1[3], en1[2],
                                  en1[1], en1[0], en0[7]})
                 | |(lane_rise & {1'b0, en0[6], en0[3], en0[4], en0[2],
                                  en1[6], en0[1], en0[0]})
                 | eot_evt;

  // ****************************************************************
  // Packet and lane reports follow the current conditions; the misc report latches.
  // ****************************************************************
  logic [7:0] misc_rpt; // Misc error report.
  logic       eot_lvl;  // End packet missing seen since last header.

  // Packet and lane reports show live conditions; eot_lvl latches; packets are never dropped here.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pkt_rpt  <= ZERO8;
      lane_rpt <= ZERO8;
      eot_lvl  <= 1'b0;
    end
    else if (clk_en)
    begin
      pkt_rpt  <= pkt_now;
      lane_rpt <= lane_now;
      if (eot_evt)
      begin
        eot_lvl <= 1'b1;
      end
      else if (hdr_evt)
      begin
        eot_lvl <= 1'b0;
      end
    end
  end

  // Command bits 2 and 0 stay zero; bits 7:3 read zero.
  assign misc_rpt = {6'b0, eot_lvl, 1'b0};

  // ****************************************************************
  // Last pixel-stream packet channel and type.
  // ****************************************************************
  logic [7:0] vc_dt; // Channel 7:6, type 5:0.

  // Only pixel stream types update the capture.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      vc_dt <= ZERO8;
    end
    else if (clk_en && hdr_evt && hid[3:0] >= DT_LO_MIN
             && hid[3:0] <= DT_LO_MAX)
    begin
      vc_dt <= hid;
    end
  end

  // ****************************************************************
  // APB slave: one wait state; unmapped addresses raise pslverr.
  // ****************************************************************
  logic       acc;      // Access phase this cycle.
  logic       wr_acc;   // Write taken this cycle.
  logic       rd_stat;  // Status read taken this cycle.
  logic [7:0] idx;      // Register index.
  logic       mapped;   // Index is known.
  logic [7:0] rd_val;   // Selected read value.
  logic [7:0] status;   // Clear-on-read flags.
  logic [7:0] err_cnt;  // Error event count.
  logic [1:0] hsw_hi;   // Hsync width high bits.
  logic [7:0] irq_stat; // Sticky event status.
  logic [7:0] irq_en;   // Event enable.

  assign acc     = psel & penable & ~pready & clk_en;
  assign wr_acc  = acc & pwrite;
  assign idx     = paddr[9:2];
  // A refused read must not clear the flags, so it is gated by the map.
  assign rd_stat = acc & ~pwrite & mapped & (idx == IDX_STATUS);

  // Read mux and map check.
  always_comb
  begin
    mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    rd_val = ZERO8;
    unique case (idx)
      IDX_STATUS:   rd_val = status;
      IDX_VC_DT:    rd_val = vc_dt;
      IDX_RPT_PKT:  rd_val = pkt_rpt;
      IDX_RPT_LANE: rd_val = lane_rpt;
      IDX_RPT_MISC: rd_val = misc_rpt;
      IDX_HSW_HI:   rd_val = {6'b0, hsw_hi};
      IDX_CONFIG:   rd_val = cfg;
      IDX_ERR_EN0:  rd_val = en0;
      IDX_ERR_EN1:  rd_val = en1;
      IDX_ERR_CNT:  rd_val = err_cnt;
      IDX_IRQ_STAT: rd_val = irq_stat;
      IDX_IRQ_EN:   rd_val = irq_en;
      IDX_IRQ_CLR:  rd_val = ZERO8;
      default:      mapped = 1'b0;
    endcase
  end

  // Answer in the second access cycle; outputs registered.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (clk_en)
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata  <= (psel & penable & ~pready & ~pwrite & mapped)
                 ? {24'h000000, rd_val} : 32'h00000000;
    end
  end

  // Writable configuration registers.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      cfg    <= CONFIG_RST;
      en0    <= ERR_EN0_RST;
      en1    <= ERR_EN1_RST;
      hsw_hi <= 2'h0;
      irq_en <= ZERO8;
    end
    else if (wr_acc && mapped)
    begin
      unique case (idx)
        IDX_CONFIG:  cfg    <= pwdata[7:0];
        IDX_ERR_EN0: en0    <= pwdata[7:0];
        IDX_ERR_EN1: en1    <= {1'b0, pwdata[6:0]};
        IDX_HSW_HI:  hsw_hi <= pwdata[1:0] & HSW_HI_MASK;
        IDX_IRQ_EN:  irq_en <= pwdata[7:0];
        default:     ;
      endcase
    end
  end

  // ****************************************************************
  // Status flags: a new event wins over the clearing read.
  // ****************************************************************
  logic [7:0] set_vec; // Events this cycle in status layout.
  assign set_vec = {1'b0, ovf_evt, unf_evt, buf_evt, 1'b0, eot_evt,
                    1'b0, any_err};

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      status <= ZERO8;
    end
    else if (clk_en)
    begin
      status <= (rd_stat ? ZERO8 : status) | set_vec;
    end
  end

  // Count enabled error events; saturates rather than wraps.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      err_cnt <= ZERO8;
    end
    else if (clk_en && any_err && err_cnt != 8'hFF)
    begin
      err_cnt <= err_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // Interrupts and error indication.
  // ****************************************************************
  logic clr_wr; // Write to the clear register.
  assign clr_wr = wr_acc & mapped & (idx == IDX_IRQ_CLR);

  // Sticky events; a set in the clearing cycle survives.
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      irq_stat <= ZERO8;
      irq      <= 1'b0;
      err_ind  <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_stat <= (irq_stat & ~(clr_wr ? pwdata[7:0] : ZERO8)) | set_vec;
      irq      <= |(irq_stat & irq_en);
      // Pulse per event, or the latched summary flag in hold mode.
      err_ind  <= cfg[CFG_HOLD] ? (status[ST_SUM] | any_err)
                                : any_err;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/rx_status_pkg.sv ====
package rx_status_pkg;

  // ****************************************************************
  // Register indices (printed offsets); byte address is the index times four.
  // ****************************************************************
  localparam logic [7:0] IDX_STATUS   = 8'h28; // Status flags index.
  localparam logic [7:0] IDX_VC_DT    = 8'h2A; // Last channel and type.
  localparam logic [7:0] IDX_RPT_PKT  = 8'h2B; // Packet error report.
  localparam logic [7:0] IDX_RPT_LANE = 8'h2C; // Lane error report.
  localparam logic [7:0] IDX_RPT_MISC = 8'h2D; // Misc error report.
  localparam logic [7:0] IDX_HSW_HI   = 8'h30; // Hsync width high bits.
  localparam logic [7:0] IDX_CONFIG   = 8'h40; // Mode control bits.
  localparam logic [7:0] IDX_ERR_EN0  = 8'h41; // Lane error enables.
  localparam logic [7:0] IDX_ERR_EN1  = 8'h42; // Packet error enables.
  localparam logic [7:0] IDX_ERR_CNT  = 8'h43; // Error event count.
  localparam logic [7:0] IDX_IRQ_STAT = 8'h44; // Sticky event status.
  localparam logic [7:0] IDX_IRQ_EN   = 8'h45; // Event enable.
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h46; // Write one to clear.

  // ****************************************************************
  // Status bit positions.
  // ****************************************************************
  localparam int ST_OVF  = 6; // Crossing-FIFO overflow.
  localparam int ST_UNF  = 5; // Crossing-FIFO underflow.
  localparam int ST_BUF  = 4; // Link buffer error.
  localparam int ST_CMD  = 3; // Command FIFO overflow, never set.
  localparam int ST_EOT  = 2; // Missing end packet.
  localparam int ST_BTA  = 1; // Read without turnaround, never set.
  localparam int ST_SUM  = 0; // Summary error.

  // ****************************************************************
  // Configuration fields and reset values.
  // ****************************************************************
  // Kept clear of the channel enables in 3:0, so writing them is harmless.
  localparam int CFG_NO_EOT = 5; // No end packet mode.
  localparam int CFG_HOLD   = 4; // Hold error as level.
  localparam logic [7:0] CONFIG_RST  = 8'h0F; // Channel enables in 3:0.
  localparam logic [7:0] ERR_EN0_RST = 8'hFF; // All lane errors on.
  localparam logic [7:0] ERR_EN1_RST = 8'h7F; // All packet errors on.
  localparam logic [7:0] ZERO8       = 8'h00; // Generic zero reset.
  localparam logic [3:0] DT_LO_MIN   = 4'hB; // Pixel stream types low.
  localparam logic [3:0] DT_LO_MAX   = 4'hE; // Pixel stream types high.
  localparam logic [1:0] HSW_HI_MASK = 2'h3; // Writable hsync bits.

endpackage

// ==== dv/rx_status_bank_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module rx_status_bank_checker
  import rx_status_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        err_ind,
  input wire logic        irq
);
  // ****
  // Bus answer properties.
  // ****
  logic rd_ok; // A good read answer stands this cycle.
  assign rd_ok = pready && !pslverr && !pwrite;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_ONE_WAIT: assert property (psel && penable && !pready && clk_en
    |=> pready) else $error("answer not one cycle after access");
  AST_PULSE: assert property (pready && clk_en |=> !pready)
    else $error("ready held longer than one cycle");
  AST_CAUSE: assert property ($rose(pready) |-> $past(psel) && $past(penable))
    else $error("ready without an access");
  AST_REFUSE: assert property (psel && penable && !pready && clk_en
    && paddr[1:0] != 2'h0 |=> pslverr && pready)
    else $error("misaligned access not refused");
  AST_ERR_DATA: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access returned data");
  AST_UPPER: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_STATUS_RSVD: assert property (
    rd_ok && paddr == {2'h0, IDX_STATUS, 2'h0}
    |-> !prdata[7] && !prdata[3] && !prdata[1])
    else $error("status unused bit set");
  AST_MISC_RSVD: assert property (
    rd_ok && paddr == {2'h0, IDX_RPT_MISC, 2'h0}
    |-> prdata[7:3] == 5'h0 && !prdata[2] && !prdata[0])
    else $error("misc report unused bit set");
  AST_RST_QUIET: assert property (disable iff (1'b0)
    !nrst && clk_en |=> !pready && !irq && !err_ind && !pslverr)
    else $error("output active in reset");
endmodule
`default_nettype wire

// ==== dv/video_source.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Video processor model: one byte clock rise per frame.
// ****
module video_source (
  output var logic       byte_clk, // Still between frames.
  output var logic       ovf,      // Crossing overflow.
  output var logic       unf,      // Crossing underflow.
  output var logic       bfe,      // Link buffer error.
  output var logic       eot,      // End without end packet.
  output var logic       hv,       // Header present.
  output var logic [7:0] hid,      // Header channel and type.
  output var logic [7:0] pk,       // Packet errors.
  output var logic [7:0] ln        // Lane errors.
);
  // Idle lines rest low; the id is inverted so stale ids are caught.
  initial
  begin
    byte_clk = 0;
    {ovf, unf, bfe, eot, hv, pk, ln} = 0;
    hid = 8'hFF;
  end
  // One frame; lag lets the source answer promptly or slowly.
  task automatic frame(input logic [4:0] k, input logic [7:0] h, p, l,
                       input int lag);
    #(17 + lag);
    {ovf, unf, bfe, eot, hv} = k;
    hid = h;
    pk = p;
    ln = l;
    #100 byte_clk = 1;
    #200 byte_clk = 0;
    #100 {ovf, unf, bfe, eot, hv, pk, ln} = 0;
    hid = ~h;
  endtask
endmodule
`default_nettype wire

// ==== dv/rx_status_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module rx_status_bank_tb
  import rx_status_pkg::*;
;
  // ****
  // Signals and bookkeeping.
  // ****
  logic        ref_clk = 0, nrst, clk_en, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, err_ind, irq, byte_clk;
  logic        ovf, unf, bfe, eot, hv;
  logic [7:0]  hid, pk, ln, b, h, last;
  logic [32:0] qe[$], qm[$]; // Expected answer and mask.
  int          n_mismatch = 0, comparisons = 0, i;
  logic [7:0]  ri [12] = '{IDX_STATUS, IDX_VC_DT, IDX_RPT_PKT,
    IDX_RPT_LANE, IDX_RPT_MISC, IDX_HSW_HI, IDX_CONFIG, IDX_ERR_EN0,
    IDX_ERR_EN1, IDX_ERR_CNT, IDX_IRQ_STAT, IDX_IRQ_EN};
  logic [7:0]  rv [12] = '{0, 0, 0, 0, 0, 0, CONFIG_RST, ERR_EN0_RST,
    ERR_EN1_RST, 0, 0, 0};
  always #25 ref_clk = ~ref_clk;
  rx_status_bank DUT (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .byte_clk(byte_clk), .fifo_ovf_ev(ovf),
    .fifo_unf_ev(unf), .buf_err_ev(bfe), .eot_miss_ev(eot),
    .hdr_valid(hv), .hdr_id(hid), .pkt_err(pk), .lane_err(ln),
    .err_ind(err_ind), .irq(irq));
  video_source vs (.byte_clk(byte_clk), .ovf(ovf), .unf(unf),
    .bfe(bfe), .eot(eot), .hv(hv), .hid(hid), .pk(pk), .ln(ln));
  // ****
  // Bus tasks and compare.
  // ****
  function automatic logic [11:0] ba(input logic [7:0] x);
    return {2'h0, x, 2'h0};
  endfunction
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Holds the request until ready is seen; one idle edge follows.
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [32:0] e, input logic [32:0] m);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w)
    begin
      qe.push_back(e);
      qm.push_back(m);
    end
    @(posedge ref_clk);
    penable <= 1;
    // Only the watchdog ends a wait that never sees ready.
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e,
    input logic [32:0] m = 33'h1_FFFF_FFFF);
    apb(0, a, 0, e, m);
  endtask
  task automatic wr(input logic [7:0] x, input logic [31:0] d);
    apb(1, ba(x), d, 0, 0);
  endtask
  // A frame, then time for the byte clock edge to be synchronised.
  task automatic ev(input logic [4:0] k, input logic [7:0] hh, p, l);
    vs.frame(k, hh, p, l, $urandom_range(0, 300));
    repeat (8) @(posedge ref_clk);
  endtask
  // Answers are judged in order as they appear on the bus.
  always @(posedge ref_clk)
    if (psel && penable && pready === 1'b1 && !pwrite && qe.size() > 0)
    begin
      cmp({pslverr, prdata} & qm[0], qe[0]);
      qe.delete(0);
      qm.delete(0);
    end
  task automatic tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #2_000_000;
    n_mismatch++;
    tally_and_finish;
  end
  // ****
  // Main sequence.
  // ****
  initial
  begin
    {nrst, psel, penable, pwrite} <= 0;
    clk_en <= 1;
    paddr <= 0;
    pwdata <= 0;
    void'($urandom(32'h71253578));
    repeat (10) @(posedge ref_clk);
    nrst <= 1;
    @(posedge ref_clk);
    foreach (ri[k]) rd(ba(ri[k]), rv[k]); // Reset values.
    rd(ba(8'h3F), 33'h1_0000_0000); // Unmapped.
    rd(12'h0A1, 33'h1_0000_0000); // Misaligned.
    wr(IDX_STATUS, 32'hFF);
    rd(ba(IDX_STATUS), 0);
    wr(IDX_HSW_HI, 32'hFF);
    rd(ba(IDX_HSW_HI), 8'h03);
    for (i = 0; i < 3; i++)
    begin
      ev(5'h10 >> i, 0, 0, 0);
      rd(ba(IDX_STATUS), 8'h40 >> i);
      rd(ba(IDX_STATUS), 0);
    end
    wr(IDX_CONFIG, 32'h0F);
    ev(5'h02, 0, 0, 0);
    rd(ba(IDX_RPT_MISC), 8'h02, 8'h02);
    rd(ba(IDX_STATUS), 8'h05);
    wr(IDX_CONFIG, 32'h2F);
    ev(5'h02, 0, 0, 0);
    rd(ba(IDX_STATUS), 0);
    last = 0;
    for (i = 10; i < 16; i++)
    begin
      h = {2'($urandom), 2'($urandom), 4'(i)};
      if (i >= 11 && i <= 14)
        last = h;
      ev(5'h01, h, 0, 0);
      rd(ba(IDX_VC_DT), last);
    end
    for (i = 0; i < 15; i++)
    begin
      if (i == 6)
        continue;
      b = 8'h01 << (i & 7);
      h = i < 8 ? IDX_RPT_PKT : IDX_RPT_LANE;
      // Reports follow the live condition, so read while it still stands.
      fork
        vs.frame(0, 0, i < 8 ? b : 8'h0, i < 8 ? 8'h0 : b, 0);
        begin
          repeat (6) @(posedge ref_clk);
          rd(ba(h), b, b);
        end
      join
      repeat (8) @(posedge ref_clk);
      rd(ba(IDX_STATUS), 1, 1);
    end
    wr(IDX_ERR_EN1, 32'h77);
    ev(0, 0, 8'h10, 0);
    rd(ba(IDX_STATUS), 0, 1);
    wr(IDX_IRQ_EN, 32'h40);
    ev(5'h10, 0, 0, 0);
    cmp(33'(irq), 1); // Interrupt raised.
    rd(ba(IDX_IRQ_STAT), 8'h40, 8'h40);
    rd(ba(IDX_STATUS), 8'h40);
    wr(IDX_IRQ_CLR, 32'h40);
    repeat (2) @(posedge ref_clk);
    cmp(33'(irq), 0); // Cleared.
    wr(IDX_IRQ_EN, 32'h00);
    ev(5'h10, 0, 0, 0);
    cmp(33'(irq), 0); // Masked.
    wr(IDX_CONFIG, 32'h1F);
    ev(5'h02, 0, 0, 0);
    repeat (4) @(posedge ref_clk);
    cmp(33'(err_ind), 1);
    rd(ba(IDX_STATUS), 8'h45);
    repeat (2) @(posedge ref_clk);
    cmp(33'(err_ind), 0);
    // Two missing end packets and fourteen enabled report errors.
    rd(ba(IDX_ERR_CNT), 8'h10);
    tally_and_finish;
  end
endmodule
bind rx_status_bank rx_status_bank_checker chk (.ref_clk(ref_clk),
  .nrst(nrst), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .err_ind(err_ind), .irq(irq));
`default_nettype wire
